// ### pkg/bbsr_consts.svh
/*
 * Constants of the buck-boost setpoint register block: offsets, field positions,
 * reset values and timing counts.
 * Assumes it is included by bare name wherever the numbers are needed.
 */
`ifndef BBSR_CONSTS_SVH
`define BBSR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define BBSR_CTRL_OFFSET 8'h19
`define BBSR_CTRL_ADDR 12'h064
`define BBSR_UNLOCK_ADDR 12'h100
`define BBSR_STATUS_ADDR 12'h104
`define BBSR_CTRL_RESET 8'hA2
`define BBSR_UNLOCK_KEY 8'h5A

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define BBSR_PSKIP_BIT 7
`define BBSR_RSVD_BIT 6
`define BBSR_CODE_MSB 5
`define BBSR_CODE_MAX 6'h34
`define BBSR_FINE_TOP 6'h0F

// ----------------------------------------------------------------------------
// Voltage mapping in millivolts
// ----------------------------------------------------------------------------
`define BBSR_FINE_BASE_MV 12'd1175
`define BBSR_FINE_STEP_MV 12'd25
`define BBSR_COARSE_BASE_MV 12'd1600
`define BBSR_COARSE_STEP_MV 12'd50
// Millivolts of the reset code 22h on the coarse slope.
`define BBSR_CTRL_RESET_MV 12'd2500

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BBSR_CLK_HZ 25000000
`define BBSR_BLANK_MS 5
`define BBSR_BLANK_CYCLES ((`BBSR_CLK_HZ / 1000) * `BBSR_BLANK_MS)

`endif

// ### pkg/bbsr_pkg.sv
/*
 * Types of the buck-boost setpoint register block.
 * Assumes nothing of its surroundings.
 */
package bbsr_pkg;

    // Write-protection state of the register.
    typedef enum logic [0:0] {
        BBSR_LOCKED,
        BBSR_UNLOCKED
    } bbsr_lock_t;

endpackage : bbsr_pkg

// ### hdl/bbsr_blank_timer.sv
/*
 * Blanking timer: a start pulse loads a down counter, busy stays high until it
 * reaches zero.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/10ps
`include "bbsr_consts.svh"

module bbsr_blank_timer #(
    parameter int unsigned CYCLES = `BBSR_BLANK_CYCLES
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Control.
    input wire logic start_in,
    output logic busy_out
);

    logic [31:0] count_r;
    logic [31:0] count_nxt;

    // A new start reloads the full interval, so back-to-back writes extend blanking.
    always_comb begin
        count_nxt = count_r;
        if (start_in) begin
            count_nxt = CYCLES;
        end else if (count_r != 32'h0000_0000) begin
            count_nxt = count_r - 32'h0000_0001;
        end
    end

    // Counter register.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_r <= 32'h0000_0000;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign busy_out = (count_r != 32'h0000_0000);

endmodule : bbsr_blank_timer

// ### hdl/bbsr_ctrl.sv
/*
 * Buck-boost converter control register with APB slave, write protection,
 * strap-selected power-up default and monitor blanking after writes.
 * Assumes APB3 master on CLK_IN, all inputs synchronous to CLK_IN.
 */
`timescale 1ns/10ps
`include "bbsr_consts.svh"

module bbsr_ctrl #(
    parameter int unsigned BLANK_CYCLES = `BBSR_BLANK_CYCLES
) (
    // Clock and reset.
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // APB slave.
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Strap.
    input wire logic DEFAULT_SELECT_STRAP_IN,
    input wire logic [7:0] STRAP_DEFAULT_IN,
    // Converter and monitor.
    output logic PULSE_SKIP_EN_OUT,
    output logic [5:0] BUCK_BOOST_VOLTAGE_CODE_OUT,
    output logic [11:0] SETPOINT_MV_OUT,
    output logic MONITOR_BLANK_OUT
);

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic pskip_r;
    logic pskip_nxt;
    logic [5:0] code_r;
    logic [5:0] code_nxt;
    bbsr_pkg::bbsr_lock_t lock_r;
    bbsr_pkg::bbsr_lock_t lock_nxt;
    logic strap_done_r;
    logic strap_done_nxt;
    logic reject_r;
    logic reject_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic [11:0] mv_r;
    logic [11:0] mv_nxt;

    logic access;
    logic wr_ctrl;
    logic wr_ok;
    logic mapped;
    logic blank_busy;

    assign access = PSEL_IN & PENABLE_IN;
    assign wr_ctrl = access & PWRITE_IN & (PADDR_IN == `BBSR_CTRL_ADDR);
    assign wr_ok = wr_ctrl & (lock_r == bbsr_pkg::BBSR_UNLOCKED);
    assign mapped = (PADDR_IN == `BBSR_CTRL_ADDR) | (PADDR_IN == `BBSR_UNLOCK_ADDR)
        | (PADDR_IN == `BBSR_STATUS_ADDR);

    // Next-state logic: strap load once after reset, writes, lock and read data.
    always_comb begin
        pskip_nxt = pskip_r;
        code_nxt = code_r;
        lock_nxt = lock_r;
        strap_done_nxt = 1'b1;
        reject_nxt = reject_r;
        prdata_nxt = prdata_r;
        // The strap is sampled at the first edge after release, never under reset.
        if (!strap_done_r && DEFAULT_SELECT_STRAP_IN) begin
            pskip_nxt = STRAP_DEFAULT_IN[`BBSR_PSKIP_BIT];
            code_nxt = STRAP_DEFAULT_IN[`BBSR_CODE_MSB:0];
        end
        if (wr_ok) begin
            pskip_nxt = PWDATA_IN[`BBSR_PSKIP_BIT];
            code_nxt = PWDATA_IN[`BBSR_CODE_MSB:0];
            reject_nxt = 1'b0;
        end else if (wr_ctrl) begin
            reject_nxt = 1'b1; // Sticky until an accepted write.
        end
        // Unlock is single-shot: any later control write, taken or not, relocks.
        if (access && PWRITE_IN && PADDR_IN == `BBSR_UNLOCK_ADDR) begin
            lock_nxt = (PWDATA_IN[7:0] == `BBSR_UNLOCK_KEY) ? bbsr_pkg::BBSR_UNLOCKED
                : bbsr_pkg::BBSR_LOCKED;
        end else if (wr_ctrl) begin
            lock_nxt = bbsr_pkg::BBSR_LOCKED;
        end
        if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            prdata_nxt = 32'h0000_0000;
            if (PADDR_IN == `BBSR_CTRL_ADDR) begin
                prdata_nxt[`BBSR_PSKIP_BIT] = pskip_r;
                prdata_nxt[`BBSR_RSVD_BIT] = 1'b0;
                prdata_nxt[`BBSR_CODE_MSB:0] = code_r;
            end else if (PADDR_IN == `BBSR_STATUS_ADDR) begin
                prdata_nxt[0] = (lock_r == bbsr_pkg::BBSR_UNLOCKED);
                prdata_nxt[1] = blank_busy;
                prdata_nxt[2] = reject_r;
                prdata_nxt[3] = (code_r > `BBSR_CODE_MAX);
            end
        end
    end

    // Millivolt view of the code: two slopes, reserved codes read as zero.
    always_comb begin
        mv_nxt = 12'h000;
        if (code_nxt <= `BBSR_FINE_TOP) begin
            mv_nxt = `BBSR_FINE_BASE_MV + 12'(code_nxt) * `BBSR_FINE_STEP_MV;
        end else if (code_nxt <= `BBSR_CODE_MAX) begin
            mv_nxt = `BBSR_COARSE_BASE_MV
                + 12'(code_nxt - 6'h10) * `BBSR_COARSE_STEP_MV;
        end
    end

    // State registers with their documented reset values.
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pskip_r <= 1'(`BBSR_CTRL_RESET >> `BBSR_PSKIP_BIT);
            code_r <= 6'(`BBSR_CTRL_RESET);
            lock_r <= bbsr_pkg::BBSR_LOCKED;
            strap_done_r <= 1'b0;
            reject_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            mv_r <= `BBSR_CTRL_RESET_MV;
        end else begin
            pskip_r <= pskip_nxt;
            code_r <= code_nxt;
            lock_r <= lock_nxt;
            strap_done_r <= strap_done_nxt;
            reject_r <= reject_nxt;
            prdata_r <= prdata_nxt;
            mv_r <= mv_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Monitor blanking
    // ------------------------------------------------------------------------
    // A write attempt counts as performed only when it actually lands.
    bbsr_blank_timer #(
        .CYCLES(BLANK_CYCLES)
    ) u_blank (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .start_in(wr_ok),
        .busy_out(blank_busy)
    );

    // Outputs.
    assign PRDATA_OUT = prdata_r;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = access & ~mapped;
    assign PULSE_SKIP_EN_OUT = pskip_r;
    assign BUCK_BOOST_VOLTAGE_CODE_OUT = code_r;
    assign SETPOINT_MV_OUT = mv_r;
    assign MONITOR_BLANK_OUT = blank_busy;

endmodule : bbsr_ctrl

// ### tb/bbsr_ctrl_checker.sv
/* Port checker of the buck-boost setpoint register, bound onto bbsr_ctrl.
   Assumes one clock, an asynchronous active-high reset and APB on CLK_IN. */
`timescale 1ns/10ps
`include "bbsr_consts.svh"
module bbsr_ctrl_checker #(parameter int unsigned BLANK_CYCLES = 20) (
    // Clock, reset and APB.
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    // Converter and monitor.
    input wire logic PULSE_SKIP_EN_OUT,
    input wire logic [5:0] BUCK_BOOST_VOLTAGE_CODE_OUT,
    input wire logic [11:0] SETPOINT_MV_OUT,
    input wire logic MONITOR_BLANK_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // Access decode, shared by the properties below.
    wire logic acc = PSEL_IN && PENABLE_IN;
    wire logic ctl = acc && PADDR_IN == `BBSR_CTRL_ADDR;
    wire logic [5:0] c = BUCK_BOOST_VOLTAGE_CODE_OUT;
    int unsigned cnt_r;
    int unsigned cnt_nxt;
    // Blanked cycles since the last control write; a refused write inside a blank would mislead it.
    always_comb cnt_nxt = (ctl && PWRITE_IN) ? 32'h0 : cnt_r + MONITOR_BLANK_OUT;
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) cnt_r <= 32'h0;
        else cnt_r <= cnt_nxt;
    end
    a_ready_high: assert property (PSEL_IN |-> PREADY_OUT) else $error("ready low");
    a_read_ctrl: assert property (ctl && !PWRITE_IN
        |-> PRDATA_OUT == {24'h0, PULSE_SKIP_EN_OUT, 1'b0, c}) else $error("control read wrong");
    // The strap load on the first edge after release moves the code without any write.
    a_change_blank: assert property (!$past(RST_IN) && !$past(RST_IN, 2) && $changed(c)
        |-> MONITOR_BLANK_OUT && $past(ctl && PWRITE_IN)) else $error("code moved without a blanked write");
    a_blank_len: assert property ($fell(MONITOR_BLANK_OUT)
        |-> cnt_r == BLANK_CYCLES) else $error("blank length");
    a_blank_cap: assert property (cnt_r <= BLANK_CYCLES) else $error("blank too long");
    a_bad_addr: assert property (acc && !(PADDR_IN inside {12'h064, 12'h100, 12'h104})
        |-> PSLVERR_OUT) else $error("unmapped access not flagged");
    a_mv_map: assert property (SETPOINT_MV_OUT == (c < 6'h10 ? 12'h497 + 12'h019 * c :
        c < 6'h35 ? 12'h640 + 12'h032 * (c - 6'h10) : 12'h000)) else $error("millivolts wrong");
endmodule : bbsr_ctrl_checker
bind bbsr_ctrl bbsr_ctrl_checker #(.BLANK_CYCLES(BLANK_CYCLES)) u_chk (.CLK_IN, .RST_IN, .PSEL_IN, .PENABLE_IN,
    .PWRITE_IN, .PADDR_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .PULSE_SKIP_EN_OUT,
    .BUCK_BOOST_VOLTAGE_CODE_OUT, .SETPOINT_MV_OUT, .MONITOR_BLANK_OUT);

// ### tb/buck_boost_setpoint_register_test.sv
/* Bench of the buck-boost setpoint register: a table of unlocked writes, then reset, lock and error cases.
   Assumes bbsr_ctrl and its bound checker are compiled before it. */
`timescale 1ns/10ps
`include "bbsr_consts.svh"
module buck_boost_setpoint_register_test;
    localparam logic [11:0] ca = `BBSR_CTRL_ADDR;
    localparam logic [11:0] ua = `BBSR_UNLOCK_ADDR;
    localparam logic [11:0] sa = `BBSR_STATUS_ADDR;
    // Inputs hold values from time zero.
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel = 1'b0;
    logic en = 1'b0;
    logic wr = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wd = 32'h0;
    logic sen = 1'b0;
    logic [7:0] sv = 8'h00;
    logic [31:0] rd;
    logic er;
    wire logic [31:0] prd;
    wire logic rdy;
    wire logic err;
    wire logic ps;
    wire logic bl;
    wire logic [5:0] code;
    wire logic [11:0] mv;
    int n_fail = 0;
    int tests_run = 0;
    int n;
    // Written byte, read-back byte, millivolts; bit 6 is set where it must vanish.
    logic [27:0] rows [5] = '{{8'h40, 8'h00, 12'h497}, {8'h0F, 8'h0F, 12'h60E}, {8'h10, 8'h10, 12'h640},
        {8'hF4, 8'hB4, 12'hD48}, {8'h80, 8'h80, 12'h497}};
    bbsr_ctrl #(.BLANK_CYCLES(20)) dut (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(sel), .PENABLE_IN(en),
        .PWRITE_IN(wr), .PADDR_IN(adr), .PWDATA_IN(wd), .PRDATA_OUT(prd), .PREADY_OUT(rdy),
        .PSLVERR_OUT(err), .DEFAULT_SELECT_STRAP_IN(sen), .STRAP_DEFAULT_IN(sv), .PULSE_SKIP_EN_OUT(ps),
        .BUCK_BOOST_VOLTAGE_CODE_OUT(code), .SETPOINT_MV_OUT(mv), .MONITOR_BLANK_OUT(bl));
    // A 40 ns clock.
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    // One APB transfer; the answer is taken at the edge where ready is seen.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        sel <= 1'b1;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        en <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        rd = prd;
        er = err;
        sel <= 1'b0;
        en <= 1'b0;
    endtask : apb
    // Reset for five cycles, then keep clear of the strap load edge.
    task automatic do_reset(input logic s, input logic [7:0] v);
        sen <= s;
        sv <= v;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset
    task automatic end_sim;
        $display("%0d checks, %0d mismatches", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    initial begin
        do_reset(1'b0, 8'h00);
        apb(1'b0, ca, 32'h0);
        chk(rd, {24'h0, `BBSR_CTRL_RESET});
        chk({ps, code, mv}, {1'b1, 6'h22, 12'h9C4});
        apb(1'b1, ca, 32'h05);
        apb(1'b0, ca, 32'h0);
        chk(rd, 32'hA2);
        // Row codes stay below 35h, and no converter is running while they are written.
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ua, `BBSR_UNLOCK_KEY);
            apb(1'b1, ca, rows[i][27:20]);
            n = 0;
            @(posedge clk);
            while (bl === 1'b1 && n < 100) begin
                n++;
                @(posedge clk);
            end
            chk(n, 20);
            apb(1'b0, ca, 32'h0);
            chk(rd, rows[i][19:12]);
            chk({ps, 1'b0, code, mv}, rows[i][19:0]);
        end
        // The second write finds the lock closed again.
        apb(1'b1, ua, `BBSR_UNLOCK_KEY);
        apb(1'b1, ca, 32'h12);
        repeat (22) @(posedge clk);
        apb(1'b1, ca, 32'h33);
        apb(1'b0, ca, 32'h0);
        chk(rd, 32'h12);
        // Status: locked, not blanking, last write refused, code not reserved.
        apb(1'b0, sa, 32'h0);
        chk(rd, 32'h4);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        do_reset(1'b1, 8'hC5);
        apb(1'b0, ca, 32'h0);
        chk(rd, 32'h85);
        end_sim();
    end
    // The run needs well under a thousand cycles, so four thousand means a hang.
    initial begin
        #160000;
        n_fail++;
        end_sim();
    end
endmodule : buck_boost_setpoint_register_test
